// ### pkg/cts_pkg.sv
package cts_pkg;
    localparam int NUM_TABLES = 3;
    localparam int NUM_CONDS = 3;
    localparam int NUM_EVAL = 9;
    localparam int NUM_SRC = 8;
    localparam int DATA_W = 16;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] COMB_OFS = 8'h08;
    localparam logic [7:0] RES_OFS = 8'h0c;
    localparam logic [7:0] COND_OFS = 8'h10;
    localparam logic [7:0] COND_END = 8'h34;
    // combination field positions in the comb register
    localparam int COMB_T1_POS = 0;
    localparam int COMB_T2_POS = 4;
    localparam int COMB_T3_POS = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SRC_NOT_USED = 2'h0,
        SRC_BLOCK = 2'h1,
        SRC_CONST = 2'h2
    } src_sel_type;

    typedef enum logic [2:0] {
        OP_EQ = 3'h0,
        OP_NE = 3'h1,
        OP_GT = 3'h2,
        OP_GE = 3'h3,
        OP_LT = 3'h4,
        OP_LE = 3'h5
    } op_type;

    typedef enum logic [1:0] {
        RES_FALSE = 2'h0,
        RES_TRUE = 2'h1,
        RES_ERROR = 2'h2,
        RES_NA = 2'h3
    } result_type;

    typedef enum logic [2:0] {
        COMB_DEFAULT = 3'h0,
        COMB_AND_ALL = 3'h1,
        COMB_OR_ALL = 3'h2,
        COMB_AND_OR = 3'h3,
        COMB_OR_AND = 3'h4
    } comb_type;

    localparam comb_type COMB_T1_RST = COMB_AND_ALL;
    localparam comb_type COMB_T2_RST = COMB_AND_ALL;
    localparam comb_type COMB_T3_RST = COMB_DEFAULT;

    // one upstream logical output
    typedef struct packed {
        logic [15:0] value;
        logic err;
        logic avail;
    } src_type;

    // condition config word, bit 0 upward: src1, num1, src2, num2, op, constant
    typedef struct packed {
        logic [15:0] konst;
        op_type op;
        logic [2:0] num2;
        src_sel_type src2;
        logic [2:0] num1;
        src_sel_type src1;
    } cond_cfg_type;

    localparam cond_cfg_type COND_CFG_RST = '{16'h0000, OP_EQ, 3'h0, SRC_NOT_USED,
                                              3'h0, SRC_NOT_USED};
endpackage

// ### rtl/condition_table_selector.sv
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module condition_table_selector
    import cts_pkg::*;
(
    input wire logic ref_clk_in, // 250 MHz clock
    input wire logic arst_n_in, // async reset, active low
    input wire logic tick_in, // update tick
    input cts_pkg::src_type src_in [cts_pkg::NUM_SRC], // upstream outputs
    input wire logic [2:0] lut_src_ok_in, // lookup table has input source
    input wire logic [47:0] lut_data_in, // lookup table data, table 1 low
    output logic [1:0] sel_index_out, // selected table 0..2
    output logic sel_valid_out, // a table is selected
    output logic no_sel_out, // evaluated, none selected
    output logic [15:0] data_out, // selected table data
    output logic data_na_out, // output not available
    input wire logic [7:0] s_axi_awaddr_in, // write address
    input wire logic s_axi_awvalid_in, // write address valid
    output logic s_axi_awready_out, // write address ready
    input wire logic [31:0] s_axi_wdata_in, // write data
    input wire logic [3:0] s_axi_wstrb_in, // byte strobes
    input wire logic s_axi_wvalid_in, // write data valid
    output logic s_axi_wready_out, // write data ready
    output logic [1:0] s_axi_bresp_out, // write response
    output logic s_axi_bvalid_out, // write response valid
    input wire logic s_axi_bready_in, // write response ready
    input wire logic [7:0] s_axi_araddr_in, // read address
    input wire logic s_axi_arvalid_in, // read address valid
    output logic s_axi_arready_out, // read address ready
    output logic [31:0] s_axi_rdata_out, // read data
    output logic [1:0] s_axi_rresp_out, // read response
    output logic s_axi_rvalid_out, // read data valid
    input wire logic s_axi_rready_in // read data ready
);
    import cts_pkg::*;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic compare(input op_type op, input logic [15:0] a,
                                     input logic [15:0] b);
        case (op)
            OP_EQ: return a == b;
            OP_NE: return a != b;
            OP_GT: return a > b;
            OP_GE: return a >= b;
            OP_LT: return a < b;
            OP_LE: return a <= b;
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic combine(input comb_type c, input result_type r1,
                                     input result_type r2, input result_type r3);
        logic t1, t2, t3;
        t1 = (r1 == RES_TRUE);
        t2 = (r2 == RES_TRUE);
        t3 = (r3 == RES_TRUE);
        case (c)
            COMB_DEFAULT: return 1'b1;
            COMB_AND_ALL: return (t1 || r1 == RES_NA) && (t2 || r2 == RES_NA)
                                 && (t3 || r3 == RES_NA);
            COMB_OR_ALL: return t1 || t2 || t3;
            COMB_AND_OR: return (t1 && t2) || t3;
            COMB_OR_AND: return (t1 || t2) && t3;
            default: return 1'b0;
        endcase
    endfunction

    cond_cfg_type cfg_q [NUM_EVAL];
    logic [11:0] comb_q;
    logic enable_q;
    result_type res_q [NUM_EVAL];
    result_type res_d [NUM_EVAL];
    src_type arg1 [NUM_EVAL];
    src_type arg2 [NUM_EVAL];
    comb_type comb [NUM_TABLES];
    logic [2:0] hit;
    logic [1:0] sel_d;
    logic bvalid_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q, rd_word;
    logic rd_hit;

    assign comb[0] = comb_type'(comb_q[COMB_T1_POS +: 3]);
    assign comb[1] = comb_type'(comb_q[COMB_T2_POS +: 3]);
    assign comb[2] = comb_type'(comb_q[COMB_T3_POS +: 3]);

    // nine evaluators, index = table*3 + condition
    for (genvar i = 0; i < NUM_EVAL; i++) begin : g_cond
        // argument one only from a block output
        assign arg1[i] = (cfg_q[i].src1 == SRC_BLOCK) ? src_in[cfg_q[i].num1] : '0;
        // argument two from a block output or the constant
        assign arg2[i] = (cfg_q[i].src2 == SRC_BLOCK) ? src_in[cfg_q[i].num2] :
                         (cfg_q[i].src2 == SRC_CONST) ? {cfg_q[i].konst, 2'b01} : '0;
        assign res_d[i] = (!arg1[i].avail || !arg2[i].avail) ? RES_NA :
                          (arg1[i].err || arg2[i].err) ? RES_ERROR :
                          compare(cfg_q[i].op, arg1[i].value, arg2[i].value) ? RES_TRUE :
                          RES_FALSE;
    end

    for (genvar t = 0; t < NUM_TABLES; t++) begin : g_tab
        assign hit[t] = combine(comb[t], res_d[3*t], res_d[3*t+1], res_d[3*t+2]);
    end

    assign sel_d = hit[0] ? 2'h0 : hit[1] ? 2'h1 : 2'h2;

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sel_index_out <= 2'h0;
            sel_valid_out <= 1'b0;
            no_sel_out <= 1'b0;
            data_out <= 16'h0000;
            data_na_out <= 1'b1;
            for (int i = 0; i < NUM_EVAL; i++) begin
                res_q[i] <= RES_NA;
            end
        end else if (!enable_q) begin
            sel_valid_out <= 1'b0;
            no_sel_out <= 1'b0;
            data_na_out <= 1'b1;
        end else if (tick_in) begin
            res_q <= res_d;
            sel_index_out <= sel_d;
            sel_valid_out <= |hit;
            no_sel_out <= ~|hit;
            data_out <= lut_data_in[16*sel_d +: 16];
            // no lookup source means not available
            data_na_out <= ~|hit | ~lut_src_ok_in[sel_d];
        end
    end

    // register bus
    logic wr_fire, rd_fire, wr_cond, op_lock;
    logic [7:0] wa, ra;
    logic [3:0] widx, ridx;
    cond_cfg_type wcfg;
    assign wr_fire = s_axi_awvalid_in && s_axi_wvalid_in && !bvalid_q;
    assign s_axi_awready_out = wr_fire;
    assign s_axi_wready_out = wr_fire;
    assign rd_fire = s_axi_arvalid_in && !rvalid_q;
    assign s_axi_arready_out = !rvalid_q;
    assign wa = {s_axi_awaddr_in[7:2], 2'b00};
    assign ra = {s_axi_araddr_in[7:2], 2'b00};
    assign widx = 4'((wa - COND_OFS) >> 2);
    assign ridx = 4'((ra - COND_OFS) >> 2);
    assign wr_cond = wa >= COND_OFS && wa < COND_END;
    assign wcfg = cond_cfg_type'(29'(merge({3'h0, cfg_q[widx]}, s_axi_wdata_in,
                                           s_axi_wstrb_in)));
    assign op_lock = wcfg.src1 != SRC_BLOCK
                     || (wcfg.src2 != SRC_BLOCK && wcfg.src2 != SRC_CONST);

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        if (ra == CTRL_OFS) begin
            rd_word = {31'h0, enable_q};
        end else if (ra == STAT_OFS) begin
            rd_word = {27'h0, data_na_out, no_sel_out, sel_valid_out, sel_index_out};
        end else if (ra == COMB_OFS) begin
            rd_word = {20'h0, comb_q};
        end else if (ra == RES_OFS) begin
            for (int i = 0; i < NUM_EVAL; i++) begin
                rd_word[2*i +: 2] = res_q[i];
            end
        end else if (ra >= COND_OFS && ra < COND_END) begin
            rd_word = {3'h0, cfg_q[ridx]};
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            enable_q <= 1'b0;
            comb_q <= 12'h000;
            comb_q[COMB_T1_POS +: 3] <= COMB_T1_RST;
            comb_q[COMB_T2_POS +: 3] <= COMB_T2_RST;
            comb_q[COMB_T3_POS +: 3] <= COMB_T3_RST;
            for (int i = 0; i < NUM_EVAL; i++) begin
                cfg_q[i] <= COND_CFG_RST;
            end
        end else if (wr_fire) begin
            if (wa == CTRL_OFS && s_axi_wstrb_in[0]) begin
                enable_q <= s_axi_wdata_in[0];
            end else if (wa == COMB_OFS) begin
                comb_q <= 12'(merge({20'h0, comb_q}, s_axi_wdata_in, s_axi_wstrb_in))
                          & 12'h777;
            end else if (wr_cond) begin
                cfg_q[widx] <= wcfg;
                // operator locked unless both sources valid
                if (op_lock) begin
                    cfg_q[widx].op <= cfg_q[widx].op;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else begin
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q <= (wa <= RES_OFS || wr_cond) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready_in) begin
                bvalid_q <= 1'b0;
            end
            if (rd_fire) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_word;
                rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready_in) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid_out = bvalid_q;
    assign s_axi_bresp_out = bresp_q;
    assign s_axi_rvalid_out = rvalid_q;
    assign s_axi_rresp_out = rresp_q;
    assign s_axi_rdata_out = rdata_q;

    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in);

    AST_COND_NA: assert property (
        enable_q && tick_in && cfg_q[0].src1 == SRC_NOT_USED |=> res_q[0] == RES_NA)
        else $error("unused source did not give n/a");
    AST_COND_ERR: assert property (
        enable_q && tick_in && arg1[0].avail && arg2[0].avail && arg1[0].err
        |=> res_q[0] == RES_ERROR)
        else $error("source error did not give error result");
    AST_COND_EQ: assert property (
        enable_q && tick_in && cfg_q[0].op == OP_EQ && res_d[0] != RES_NA
        && res_d[0] != RES_ERROR && arg1[0].value == arg2[0].value
        |=> res_q[0] == RES_TRUE)
        else $error("equal arguments did not give true");
    AST_OP_LOCK: assert property (
        wr_fire && wr_cond && op_lock
        |=> cfg_q[$past(widx)].op == $past(cfg_q[widx].op))
        else $error("operator changed without valid sources");
    AST_PRIORITY: assert property (
        enable_q && tick_in && hit[0] |=> sel_valid_out && sel_index_out == 2'h0)
        else $error("table one hit but not selected");
    AST_DEFAULT: assert property (
        enable_q && tick_in && !hit[0] && !hit[1] && comb[2] == COMB_DEFAULT
        |=> sel_valid_out && sel_index_out == 2'h2)
        else $error("default table not selected");
    AST_DISABLED: assert property (
        !enable_q |=> !sel_valid_out && !no_sel_out)
        else $error("selection while disabled");
    AST_NO_SEL: assert property (
        enable_q && tick_in && hit == 3'b000 |=> no_sel_out && !sel_valid_out ##0 data_na_out)
        else $error("missing no-selection flag");
    AST_LUT_NA: assert property (
        enable_q && tick_in && |hit && !lut_src_ok_in[sel_d] |=> data_na_out)
        else $error("missing not-available flag");
    AST_BRESP: assert property (
        wr_fire |=> s_axi_bvalid_out ##0 (s_axi_bvalid_out && !s_axi_bready_in)[*1]
        |=> s_axi_bvalid_out)
        else $error("write response dropped");

    COV_SEL_T1: cover property (enable_q && tick_in ##1 sel_valid_out && sel_index_out == 2'h0);
    COV_SEL_T3: cover property (enable_q && tick_in ##1 sel_valid_out && sel_index_out == 2'h2);
    COV_NONE: cover property (enable_q && tick_in ##1 no_sel_out);
    COV_ERR: cover property (res_q[0] == RES_ERROR);
endmodule // condition_table_selector

// ### tb/upstream_src_model.sv
`timescale 1ns/1ps
module upstream_src_model
    import cts_pkg::*;
(
    input wire logic ref_clk_in, // clock
    input wire logic arst_n_in, // async reset, active low
    input wire logic [15:0] val_in [cts_pkg::NUM_SRC], // requested values
    input wire logic [7:0] err_in, // error state per source
    input wire logic [7:0] avail_in, // availability per source
    output cts_pkg::src_type src_out [cts_pkg::NUM_SRC] // logical outputs
);
    import cts_pkg::*;
    logic [15:0] churn_q;
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            churn_q <= 16'ha5c3;
            for (int i = 0; i < NUM_SRC; i++) begin
                src_out[i] <= '{16'h0000, 1'b0, 1'b0};
            end
        end else begin
            churn_q <= {churn_q[14:0], churn_q[15] ^ churn_q[13]};
            for (int i = 0; i < NUM_SRC; i++) begin
                // an unavailable output carries no stable value
                src_out[i].value <= avail_in[i] ? val_in[i] : churn_q;
                src_out[i].err <= err_in[i];
                src_out[i].avail <= avail_in[i];
            end
        end
    end
endmodule // upstream_src_model

// ### tb/test_condition_table_selector.sv
`timescale 1ns/1ps
`define CHK(nm, e, s) begin check_count++; if ((e) !== (s)) begin fail_count++; \
    $display("BAD %s exp %h got %h", nm, e, s); end end
module test_condition_table_selector;
    import cts_pkg::*;
    logic ref_clk_in = 0, arst_n_in = 0, tick_in = 0;
    src_type src_w [NUM_SRC];
    logic [15:0] vals [NUM_SRC];
    logic [7:0] errs = 0, avails = 0, s_axi_awaddr_in = 0, s_axi_araddr_in = 0;
    logic [2:0] lut_ok = 0;
    logic [47:0] lut = 0;
    logic [1:0] idx, bresp, rresp;
    logic valid, nosel, na, awready, wready, bvalid, arready, rvalid;
    logic [15:0] dout;
    logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0;
    logic s_axi_arvalid_in = 0, s_axi_rready_in = 0;
    logic [31:0] s_axi_wdata_in = 0, rdata;
    int fail_count = 0, check_count = 0;
    logic [1:0] wq [$];
    logic [33:0] rq [$];

    always #2 ref_clk_in = ~ref_clk_in;

    upstream_src_model far_end (.ref_clk_in, .arst_n_in, .val_in(vals), .err_in(errs),
        .avail_in(avails), .src_out(src_w));
    condition_table_selector uut (.ref_clk_in, .arst_n_in, .tick_in, .src_in(src_w),
        .lut_src_ok_in(lut_ok), .lut_data_in(lut), .sel_index_out(idx),
        .sel_valid_out(valid), .no_sel_out(nosel), .data_out(dout), .data_na_out(na),
        .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out(awready),
        .s_axi_wdata_in, .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in,
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in,
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in);

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic step(inout int n);
        @(posedge ref_clk_in);
        n++;
        if (n > 50) begin
            fail_count++;
            tally_and_finish();
        end
    endtask

    // answers are compared against the oldest note
    always @(posedge ref_clk_in) begin : watch
        logic [33:0] note;
        if (s_axi_bready_in && bvalid) begin
            note = (wq.size() > 0) ? {32'h0, wq.pop_front()} : 34'h3_ffff_ffff;
            `CHK("bresp", note[1:0], bresp)
        end
        if (s_axi_rready_in && rvalid) begin
            note = (rq.size() > 0) ? rq.pop_front() : 34'h3_ffff_ffff;
            `CHK("rresp/rdata", note, {rresp, rdata})
        end
    end

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        wq.push_back(e);
        @(posedge ref_clk_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        n = 0;
        do step(n); while (!(awready && wready));
        s_axi_awvalid_in <= 1'b0;
        s_axi_wvalid_in <= 1'b0;
        n = 0;
        do step(n); while (!bvalid);
        s_axi_bready_in <= 1'b1;
        step(n);
        s_axi_bready_in <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        rq.push_back({e, d});
        @(posedge ref_clk_in);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in <= 1'b1;
        n = 0;
        do step(n); while (!arready);
        s_axi_arvalid_in <= 1'b0;
        n = 0;
        do step(n); while (!rvalid);
        s_axi_rready_in <= 1'b0;
    endtask

    task automatic pulse_tick();
        repeat (2) @(posedge ref_clk_in);
        tick_in <= 1'b1;
        @(posedge ref_clk_in);
        tick_in <= 1'b0;
        @(posedge ref_clk_in);
    endtask

    function automatic logic [31:0] cw(input logic [1:0] s1, input logic [2:0] n1,
        input logic [1:0] s2, input logic [2:0] n2, input logic [2:0] op, input logic [15:0] k);
        return {3'h0, k, op, n2, s2, n1, s1};
    endfunction

    function automatic logic [1:0] cmp(input logic [2:0] op, input logic [15:0] a, b);
        case (op)
            3'h0: return {1'b0, a == b};
            3'h1: return {1'b0, a != b};
            3'h2: return {1'b0, a > b};
            3'h3: return {1'b0, a >= b};
            3'h4: return {1'b0, a < b};
            default: return {1'b0, a <= b};
        endcase
    endfunction

    // true or not applicable both carry bit 0 high
    function automatic logic hit(input logic [2:0] c, input logic [1:0] a, b, d);
        case (c)
            3'h0: return 1'b1;
            3'h1: return a[0] && b[0] && d[0];
            3'h2: return (a == 2'h1) || (b == 2'h1) || (d == 2'h1);
            3'h3: return ((a == 2'h1) && (b == 2'h1)) || (d == 2'h1);
            3'h4: return ((a == 2'h1) || (b == 2'h1)) && (d == 2'h1);
            default: return 1'b0;
        endcase
    endfunction

    initial begin
        logic [1:0] r [3];
        logic [2:0] c1, c2, c3, op, n;
        logic [15:0] a, k;
        logic blk;
        int sel;
        for (int i = 0; i < NUM_SRC; i++) vals[i] = 16'h0000;
        void'($urandom(32'h22705ec1));
        repeat (3) @(posedge ref_clk_in);
        arst_n_in <= 1'b1;
        axi_rd(CTRL_OFS, 32'h0, RESP_OKAY);
        axi_rd(COMB_OFS, 32'h0000_0011, RESP_OKAY);
        axi_rd(RES_OFS, 32'h0003_ffff, RESP_OKAY);
        axi_rd(COND_OFS, 32'h0, RESP_OKAY);
        axi_rd(STAT_OFS, 32'h10, RESP_OKAY);
        axi_rd(COND_END, 32'h0, RESP_SLVERR);
        axi_wr(COND_END, 32'hffff_ffff, RESP_SLVERR);
        axi_wr(STAT_OFS, 32'hffff_ffff, RESP_OKAY);
        axi_rd(STAT_OFS, 32'h10, RESP_OKAY);
        axi_wr(COND_OFS, cw(SRC_NOT_USED, 0, SRC_CONST, 0, 3'h3, 16'h5), RESP_OKAY);
        axi_rd(COND_OFS, cw(SRC_NOT_USED, 0, SRC_CONST, 0, OP_EQ, 16'h5), RESP_OKAY);
        axi_wr(COND_OFS + 8'h04, cw(SRC_BLOCK, 0, 2'h3, 0, 3'h2, 16'h5), RESP_OKAY);
        axi_rd(COND_OFS + 8'h04, cw(SRC_BLOCK, 0, 2'h3, 0, OP_EQ, 16'h5), RESP_OKAY);
        axi_wr(CTRL_OFS, 32'h1, RESP_OKAY);
        pulse_tick();
        axi_rd(RES_OFS, 32'h0003_ffff, RESP_OKAY);
        `CHK("sel all n/a", {valid, nosel, idx, na}, 5'b10001)
        avails <= 8'hff;
        for (int i = 0; i < 24; i++) begin
            op = 3'(i % 6);
            n = 3'(i % 8);
            blk = i[0];
            a = 16'($urandom_range(3));
            k = 16'($urandom_range(3));
            vals[n] <= a;
            if (blk) vals[(n + 1) % 8] <= k;
            axi_wr(COND_OFS, cw(SRC_BLOCK, n, blk ? SRC_BLOCK : SRC_CONST, 3'(n + 1), op,
                blk ? 16'h0 : k), RESP_OKAY);
            pulse_tick();
            axi_rd(RES_OFS, {14'h0, 16'hffff, cmp(op, a, k)}, RESP_OKAY);
        end
        for (int j = 0; j < 2; j++) begin
            errs <= 8'hff;
            avails <= j ? 8'h00 : 8'hff;
            pulse_tick();
            axi_rd(RES_OFS, {14'h0, 16'hffff, j ? 2'h3 : 2'h2}, RESP_OKAY);
            `CHK("sel after err", {valid, idx}, {1'b1, j ? 2'h0 : 2'h1})
        end
        for (int i = 0; i < 3; i++) begin
            axi_wr(COND_OFS + 8'(4 * i), cw(SRC_BLOCK, 3'(i), SRC_CONST, 0, OP_EQ, 16'h1),
                RESP_OKAY);
        end
        for (int t = 0; t < 80; t++) begin
            c1 = 3'($urandom_range(4));
            c2 = $urandom_range(1) ? COMB_DEFAULT : COMB_OR_ALL;
            c3 = $urandom_range(1) ? COMB_DEFAULT : COMB_OR_ALL;
            for (int i = 0; i < 3; i++) begin
                r[i] = 2'($urandom_range(3));
                vals[i] <= (r[i] == 2'h1) ? 16'h0001 : 16'h0002;
                errs[i] <= (r[i] == 2'h2);
                avails[i] <= (r[i] != 2'h3);
            end
            lut <= {16'($urandom()), 32'($urandom())};
            lut_ok <= 3'($urandom_range(7));
            axi_wr(COMB_OFS, {21'h0, c3, 1'b0, c2, 1'b0, c1}, RESP_OKAY);
            pulse_tick();
            sel = hit(c1, r[0], r[1], r[2]) ? 0 : hit(c2, 3, 3, 3) ? 1 : hit(c3, 3, 3, 3) ? 2 : 3;
            `CHK("valid/nosel", {valid, nosel}, {sel < 3, sel == 3})
            if (sel < 3) begin
                `CHK("index", idx, 2'(sel))
                `CHK("na", na, !lut_ok[sel])
                if (lut_ok[sel]) `CHK("data", dout, lut[16 * sel +: 16])
            end else `CHK("na", na, 1'b1)
            axi_rd(RES_OFS, {14'h0, 12'hfff, r[2], r[1], r[0]}, RESP_OKAY);
        end
        axi_wr(CTRL_OFS, 32'h0, RESP_OKAY);
        pulse_tick();
        `CHK("disabled", {valid, nosel, na}, 3'b001)
        repeat (2) @(posedge ref_clk_in);
        tally_and_finish();
    end
endmodule // test_condition_table_selector
